// [src/ris_pkg.sv]
// package for the remappable input selector
// assumes a 32-bit apb slave; selector registers occupy low 16 bits
package ris_pkg;
    localparam int          RIS_SEL_W      = 6;
    localparam int          RIS_NUM_PINS   = 36;
    localparam int          RIS_NUM_SEL    = 21;
    localparam int          RIS_NUM_REGS   = 11;
    localparam int          RIS_ADDR_W     = 8;
    localparam logic [5:0]  RIS_SEL_GND    = 6'h3f;
    localparam logic [5:0]  RIS_PIN_MAX    = 6'h23;
    localparam int          RIS_LO_LSB     = 0;
    localparam int          RIS_HI_LSB     = 8;
    localparam logic [15:0] RIS_REG_RESET  = 16'h3f3f;

    // register byte offsets
    localparam logic [7:0] RIS_OFS_IRQ1    = 8'h00;
    localparam logic [7:0] RIS_OFS_IRQ2    = 8'h04;
    localparam logic [7:0] RIS_OFS_TMRA    = 8'h08;
    localparam logic [7:0] RIS_OFS_TMRB    = 8'h0c;
    localparam logic [7:0] RIS_OFS_CAP     = 8'h10;
    localparam logic [7:0] RIS_OFS_CMPF    = 8'h14;
    localparam logic [7:0] RIS_OFS_UART    = 8'h18;
    localparam logic [7:0] RIS_OFS_SPI     = 8'h1c;
    localparam logic [7:0] RIS_OFS_SPISS   = 8'h20;
    localparam logic [7:0] RIS_OFS_PWM_FAULT_IN_1    = 8'h24;
    localparam logic [7:0] RIS_OFS_FLT23   = 8'h28;
    localparam logic [7:0] RIS_OFS_FLT45   = 8'h2c;
    localparam logic [7:0] RIS_OFS_FLT67   = 8'h30;
    localparam logic [7:0] RIS_OFS_FLT8S1  = 8'h34;
    localparam logic [7:0] RIS_OFS_SYNC2   = 8'h38;

    // selector index: which register, which half (0 low, 1 high)
    localparam int SEL_IRQ1 = 0;
    localparam int SEL_IRQ2 = 1;
    localparam int SEL_TMRA = 2;
    localparam int SEL_TMRB = 3;
    localparam int SEL_CAP  = 4;
    localparam int SEL_CMPF = 5;
    localparam int SEL_URX  = 6;
    localparam int SEL_UCTS = 7;
    localparam int SEL_SDI  = 8;
    localparam int SEL_SCK  = 9;
    localparam int SEL_SS   = 10;
    localparam int SEL_PWM_FAULT_IN_1 = 11;
    localparam int SEL_FLT2 = 12;
    localparam int SEL_FLT3 = 13;
    localparam int SEL_FLT4 = 14;
    localparam int SEL_FLT5 = 15;
    localparam int SEL_PWM_FAULT_IN_6 = 16;
    localparam int SEL_PWM_FAULT_IN_7 = 17;
    localparam int SEL_FLT8 = 18;
    localparam int SEL_SYN1 = 19;
    localparam int SEL_SYN2 = 20;
endpackage

// [src/ris_selector.sv]
// remappable input selector: apb registers of 6-bit pin codes, each
// routing one remappable pin (or ground) to a peripheral input
// assumes pins already synchronous to pclk; one clock domain
`timescale 1ns/1ps

import ris_pkg::*;

// Operation
// [RULE1] one selector per remappable peripheral input
// [RULE2] six-bit read/write codes steer routing
// [RULE3] codes 0..35 connect that pin
// [RULE4] all-ones ties low; reset all ones
// [RULE5] fault1 code at bits 13:8 only
// [RULE6] fault7 at 13:8, fault6 at 5:0
// [RULE7] unimplemented bits ignore writes, read zero
// [RULE8] sync inputs 1,2 in distinct registers
// [RULE9] spi data/clock share; select separate
// [RULE10] compare fault input has own selector
// [RULE11] compare fault tristates compare outputs
// [RULE12] codes 36..62 drive constant low
module ris_selector (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [ris_pkg::RIS_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                     pwdata,
    input  wire logic [3:0]                      pstrb,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic [ris_pkg::RIS_NUM_PINS-1:0] remappable_pin_n,
    input  wire logic                            compare_out_drive,
    output logic                                 compare_out,
    output logic                                 compare_out_oe_n,
    output logic                                 ext_irq_in_1,
    output logic                                 ext_irq_in_2,
    output logic                                 timer_a_clock_in,
    output logic                                 timer_b_clock_in,
    output logic                                 capture_in,
    output logic                                 compare_fault_in,
    output logic                                 uart_receive_in,
    output logic                                 uart_clear_to_send_in,
    output logic                                 spi_serial_in,
    output logic                                 spi_clock_in,
    output logic                                 spi_select_in,
    output logic                                 pwm_fault_in_1,
    output logic                                 pwm_fault_in_2,
    output logic                                 pwm_fault_in_3,
    output logic                                 pwm_fault_in_4,
    output logic                                 pwm_fault_in_5,
    output logic                                 pwm_fault_in_6,
    output logic                                 pwm_fault_in_7,
    output logic                                 pwm_fault_in_8,
    output logic                                 pwm_sync_in_1,
    output logic                                 pwm_sync_in_2
);
    import ris_pkg::*;

    // register holding each selector, and its half
    localparam logic [7:0] SEL_OFS [RIS_NUM_SEL] = '{
        RIS_OFS_IRQ1, RIS_OFS_IRQ2, RIS_OFS_TMRA, RIS_OFS_TMRB,
        RIS_OFS_CAP, RIS_OFS_CMPF, RIS_OFS_UART, RIS_OFS_UART,
        RIS_OFS_SPI, RIS_OFS_SPI, RIS_OFS_SPISS, RIS_OFS_PWM_FAULT_IN_1,
        RIS_OFS_FLT23, RIS_OFS_FLT23, RIS_OFS_FLT45, RIS_OFS_FLT45,
        RIS_OFS_FLT67, RIS_OFS_FLT67, RIS_OFS_FLT8S1, RIS_OFS_FLT8S1,
        RIS_OFS_SYNC2};
    localparam bit SEL_HI [RIS_NUM_SEL] = '{
        1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1,
        1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1,
        1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

    logic [RIS_SEL_W-1:0]    code_r  [RIS_NUM_SEL];
    logic [RIS_NUM_SEL-1:0]  hit;
    logic [RIS_NUM_SEL-1:0]  routed;
    logic [15:0]             rd_part [RIS_NUM_SEL];
    logic [31:0]             rd_mux;
    logic                    any_hit;
    logic                    acc_wr;
    logic                    acc_rd;
    logic [31:0]             prdata_r;

    assign acc_wr  = psel & penable & pwrite;
    assign acc_rd  = psel & ~penable & ~pwrite;
    assign any_hit = |hit;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~any_hit;

    genvar g;
    generate
        for (g = 0; g < RIS_NUM_SEL; g++) begin : g_sel
            localparam int LSB = SEL_HI[g] ? RIS_HI_LSB : RIS_LO_LSB;
            localparam int LN  = LSB / 8;
            logic [RIS_SEL_W-1:0] wr_code;
            assign hit[g]     = (paddr == SEL_OFS[g]);
            assign wr_code    = pwdata[LSB +: RIS_SEL_W]; // RULE7
            // only the selector field is stored; other bits read zero
            assign rd_part[g] = hit[g]
                ? (16'(code_r[g]) << LSB) : 16'h0000; // RULE7
            // codes above the top pin fall through to ground
            assign routed[g]  = (code_r[g] <= RIS_PIN_MAX)
                ? remappable_pin_n[code_r[g]] : 1'b0; // RULE3 RULE12
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    code_r[g] <= RIS_SEL_GND; // RULE4
                end else if (acc_wr && hit[g] && pstrb[LN]) begin
                    code_r[g] <= wr_code; // RULE2
                end
            end
        end
    endgenerate

    always_comb begin
        rd_mux = 32'h0000_0000;
        for (int i = 0; i < RIS_NUM_SEL; i++) begin
            rd_mux[15:0] = rd_mux[15:0] | rd_part[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (acc_rd) begin
            prdata_r <= rd_mux;
        end
    end
    assign prdata = prdata_r;

    // peripheral input routing
    assign ext_irq_in_1          = routed[SEL_IRQ1]; // RULE1
    assign ext_irq_in_2          = routed[SEL_IRQ2];
    assign timer_a_clock_in      = routed[SEL_TMRA];
    assign timer_b_clock_in      = routed[SEL_TMRB];
    assign capture_in            = routed[SEL_CAP];
    assign compare_fault_in      = routed[SEL_CMPF]; // RULE10
    assign uart_receive_in       = routed[SEL_URX];
    assign uart_clear_to_send_in = routed[SEL_UCTS];
    assign spi_serial_in         = routed[SEL_SDI]; // RULE9
    assign spi_clock_in          = routed[SEL_SCK];
    assign spi_select_in         = routed[SEL_SS];
    assign pwm_fault_in_1        = routed[SEL_PWM_FAULT_IN_1]; // RULE5
    assign pwm_fault_in_2        = routed[SEL_FLT2];
    assign pwm_fault_in_3        = routed[SEL_FLT3];
    assign pwm_fault_in_4        = routed[SEL_FLT4];
    assign pwm_fault_in_5        = routed[SEL_FLT5];
    assign pwm_fault_in_6        = routed[SEL_PWM_FAULT_IN_6]; // RULE6
    assign pwm_fault_in_7        = routed[SEL_PWM_FAULT_IN_7]; // RULE6
    assign pwm_fault_in_8        = routed[SEL_FLT8];
    assign pwm_sync_in_1         = routed[SEL_SYN1]; // RULE8
    assign pwm_sync_in_2         = routed[SEL_SYN2]; // RULE8

    // fault high releases the compare pin (oe_n high = not driven)
    assign compare_out      = compare_out_drive;
    assign compare_out_oe_n = compare_fault_in; // RULE11
endmodule

// [verification/ris_selector_sva.sv]
// checker: bus answer and compare pin release of the input selector
// assumes binding onto ris_selector, single pclk domain
`timescale 1ns/1ps
module ris_selector_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        compare_out_oe_n,
    input wire logic        compare_fault_in
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd; psel && !penable && !pwrite ##1 psel && penable; endsequence
    sequence s_acc; psel && penable; endsequence
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_unmapped_err: assert property (s_acc ##0 paddr > 8'h38 |-> pslverr)
        else $error("no error on unmapped address");
    a_mapped_ok: assert property (s_acc ##0 (paddr <= 8'h38 && paddr[1:0] == 2'h0)
        |-> !pslverr)
        else $error("error on mapped address");
    a_pad_zero: assert property (s_rd |-> prdata[31:14] == 18'h0
        && prdata[7:6] == 2'h0) else $error("unused bits read nonzero");
    a_pwm_fault_in_1_low: assert property (s_rd ##0 paddr == 8'h24 |-> prdata[7:0] == 8'h0)
        else $error("fault1 low byte nonzero");
    a_rd_holds: assert property (s_rd ##1 !psel |-> $stable(prdata))
        else $error("read data moved after access");
    a_fault_rel: assert property (compare_fault_in |-> compare_out_oe_n)
        else $error("compare pin driven during fault");
    a_fault_drv: assert property (!compare_fault_in |=> !compare_out_oe_n
        || compare_fault_in) else $error("compare pin released without fault");
endmodule
bind ris_selector ris_selector_sva u_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_out_oe_n(compare_out_oe_n), .compare_fault_in(compare_fault_in));

// [verification/ris_periph_model.sv]
// peripheral side: samples routed inputs on every rising clock edge
// assumes routed inputs are levels synchronous to pclk
`timescale 1ns/1ps
module ris_periph_model (
    input  wire logic        pclk,
    input  wire logic [20:0] route_in,
    output logic      [20:0] seen
);
    always_ff @(posedge pclk) begin
        seen <= route_in;
    end
endmodule

// [verification/tb.sv]
// testbench: random selector writes, read-back and routing checks
// assumes apb slave of ris_selector and a peripheral sampling model
`timescale 1ns/1ps
module tb;
    import ris_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        drv = 0, pready, pslverr, oe_n, cout, err;
    logic [7:0]  paddr = 0, a;
    logic [31:0] pwdata = 0, prdata, rd, d, lfsr = 32'd54;
    logic [3:0]  pstrb = 0, s;
    logic [35:0] pins = 0;
    logic [20:0] r, seen;
    logic [15:0] shadow [0:15], mk;
    logic [5:0]  cn [4] = '{6'h00, 6'h23, 6'h24, 6'h3f};
    int          mismatches = 0, n_checks = 0;
    always #2 pclk = ~pclk;
    ris_selector dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .remappable_pin_n(pins), .compare_out_drive(drv), .compare_out(cout),
        .compare_out_oe_n(oe_n), .ext_irq_in_1(r[0]), .ext_irq_in_2(r[1]),
        .timer_a_clock_in(r[2]), .timer_b_clock_in(r[3]), .capture_in(r[4]),
        .compare_fault_in(r[5]), .uart_receive_in(r[6]),
        .uart_clear_to_send_in(r[7]), .spi_serial_in(r[8]),
        .spi_clock_in(r[9]), .spi_select_in(r[10]), .pwm_fault_in_1(r[11]),
        .pwm_fault_in_2(r[12]), .pwm_fault_in_3(r[13]),
        .pwm_fault_in_4(r[14]), .pwm_fault_in_5(r[15]),
        .pwm_fault_in_6(r[16]), .pwm_fault_in_7(r[17]),
        .pwm_fault_in_8(r[18]), .pwm_sync_in_1(r[19]), .pwm_sync_in_2(r[20]));
    ris_periph_model pm (.pclk(pclk), .route_in(r), .seen(seen));
    function automatic logic [15:0] msk(input logic [7:0] x);
        msk = 16'h0;
        msk[5:0] = {6{x <= 8'h20 || (x >= 8'h28 && x <= 8'h34)}};
        msk[13:8] = {6{x == 8'h18 || x == 8'h1c || x >= 8'h24}};
        if (x > 8'h38) msk = 16'h0;
    endfunction
    function automatic logic ex(input int i);
        logic [7:0] o;
        logic [5:0] c;
        o = i < 6 ? 8'(4 * i) : i < 10 ? 8'(24 + 4 * ((i - 6) / 2)) :
            i == 10 ? 8'h20 : 8'(36 + 4 * ((i - 10) / 2));
        c = (i == 20 || (i > 5 && i % 2 == 1)) ? shadow[o[5:2]][13:8]
                                               : shadow[o[5:2]][5:0];
        return c <= 6'h23 ? pins[c] : 1'b0;
    endfunction
    function automatic logic [31:0] lfsr_step(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] v, e);
        n_checks++;
        if (v !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, v);
        end
    endtask
    task automatic report_and_stop();
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [7:0] x,
                        input logic [31:0] dd, input logic [3:0] ss);
        int k;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= x;
        pwdata <= dd;
        pstrb <= ss;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin mismatches++; report_and_stop(); end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    initial begin
        for (int i = 0; i < 16; i++) shadow[i] = 16'h3f3f & msk(8'(4 * i));
        repeat (6) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 16; i++) begin
            xfer(0, 8'(4 * i), 0, 0);
            chk("reset value", rd, {16'h0, shadow[i]});
        end
        for (int t = 0; t < 300; t++) begin
            lfsr = lfsr_step(lfsr);
            a = {2'b0, lfsr[3:0], 2'b0};
            d = {lfsr[15:0], lfsr[31:16]};
            if (t % 3 == 0) begin d[5:0] = cn[t % 4]; d[13:8] = cn[(t + 1) % 4]; end
            s = lfsr[9] ? 4'hf : lfsr[23:20];
            xfer(1, a, d, s);
            chk("slverr", err, a > 8'h38);
            mk = msk(a);
            if (s[0]) shadow[a[5:2]][7:0] = d[7:0] & mk[7:0];
            if (s[1]) shadow[a[5:2]][15:8] = d[15:8] & mk[15:8];
            xfer(0, a, 0, 0);
            chk("readback", rd, {16'h0, shadow[a[5:2]]});
            pins <= {lfsr[27:24], lfsr};
            drv <= lfsr[5];
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            for (int i = 0; i < 21; i++) begin
                chk("route", r[i], ex(i));
                chk("periph", seen[i], ex(i));
            end
            chk("pin release", oe_n, ex(5));
            chk("compare level", cout, drv);
        end
        report_and_stop();
    end
endmodule
